/* File: pkg/cmx_pkg.sv */
// shared constants and types for the codec mixer control register bank
package cmx_pkg;

   // -----------------------------------------------------------------
   // clock and serial timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000; // core clock rate
   localparam int BIT_CLKS = 4; // core clocks per serial bit
   localparam logic [1:0] PH_RISE = 2'h0; // sclk rises, sout changes
   localparam logic [1:0] PH_FALL = 2'h2; // sclk falls
   localparam logic [1:0] PH_SAMP = 2'h3; // synced sin is sampled
   localparam logic [5:0] BIT_LAST = 6'h3F; // last bit of 64-bit frame
   localparam logic [5:0] BIT_WR_FLAG = 6'h10; // write flag position
   localparam logic [5:0] BIT_DATA_END = 6'h1F; // last index data bit
   localparam logic [5:0] BIT_RET_START = 6'h30; // returned word start
   localparam logic [3:0] RET_MSB = 4'hF; // msb of returned word

   // mute button debounce time and its cycle count
   localparam int MUTE_DEB_US = 10_000;
   localparam int MUTE_DEB_CYC = (CLK_HZ / 1_000_000) * MUTE_DEB_US;

   // -----------------------------------------------------------------
   // register indexes
   // -----------------------------------------------------------------
   localparam logic [4:0] IDX_R_ADC = 5'h06;
   localparam logic [4:0] IDX_L_ADC = 5'h07;
   localparam logic [4:0] IDX_R_DAC = 5'h08;
   localparam logic [4:0] IDX_L_DAC = 5'h09;
   localparam logic [4:0] IDX_LINE_ATT = 5'h0A;
   localparam logic [4:0] IDX_OUT_MUTE = 5'h0B;
   localparam logic [4:0] IDX_MONO_IO = 5'h0C;
   localparam logic [4:0] IDX_C1_IN = 5'h0D;
   localparam logic [4:0] IDX_C1_OUT = 5'h0E;
   localparam logic [4:0] IDX_C2_IN = 5'h0F;
   localparam logic [4:0] IDX_C2_OUT = 5'h10;

   // -----------------------------------------------------------------
   // writable bit masks and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] MASK_SUM = 8'h3F;
   localparam logic [7:0] MASK_ATT = 8'hFF;
   localparam logic [7:0] MASK_MUTE = 8'h0F;
   localparam logic [7:0] MASK_MONO = 8'h1F;
   localparam logic [7:0] MASK_C1_IN = 8'h01;
   localparam logic [7:0] MASK_C1_OUT = 8'h07;
   localparam logic [7:0] MASK_C2_IN = 8'hFF;
   localparam logic [7:0] MASK_C2_OUT = 8'h0F;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_MONO = 8'h11; // loop on, -10 dB input
   localparam logic RST_MUTE_STATE = 1'b1; // external mute: unmuted

   // -----------------------------------------------------------------
   // gain steps in dB
   // -----------------------------------------------------------------
   localparam int LOUT_STEP_DB = 3;
   localparam int MONO_STEP_DB = 10;
   localparam int C1_IN_GAIN_DB = 6;
   localparam int TX_ATTEN_DB = 6;
   localparam int RX_BASE_DB = -4;
   localparam int RX_STEP_DB = 4;
   localparam int PREAMP_DB = 20;

   // -----------------------------------------------------------------
   // register layouts
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] zero;
      logic dac_en; // dac wraparound or main dac
      logic mono_in_en;
      logic mic_en;
      logic line3_en;
      logic line2_en;
      logic line1_en;
   } cmx_sum_t;

   typedef struct packed {
      logic [3:0] left_out_atten_code;
      logic [3:0] right_out_atten_code;
   } cmx_atten_t;

   typedef struct packed {
      logic [2:0] zero;
      logic external_mute_state;
      logic left_out2_en;
      logic left_out1_en;
      logic right_out2_en;
      logic right_out1_en;
   } cmx_mute_t;

   typedef struct packed {
      logic [2:0] zero;
      logic mono_loop_en;
      logic mono_out_right_dac_en;
      logic mono_out_left_dac_en;
      logic [1:0] mono_in_atten_sel;
   } cmx_mono_t;

   typedef struct packed {
      logic [6:0] zero;
      logic codec1_in_gain_sel;
   } cmx_c1in_t;

   typedef struct packed {
      logic [4:0] zero;
      logic codec1_tx_atten;
      logic codec1_tx2_en;
      logic codec1_diff_tx_en;
   } cmx_c1out_t;

   typedef struct packed {
      logic [1:0] codec2_line_rx_gain;
      logic codec2_mic_left_en;
      logic codec2_mic_right_en;
      logic codec2_line_rx_en;
      logic codec2_handset_rx_en;
      logic [1:0] codec2_handset_rx_gain;
   } cmx_c2in_t;

   typedef struct packed {
      logic [3:0] zero;
      logic codec2_tx_atten;
      logic codec2_handset_tx_c_en;
      logic codec2_handset_tx_b_en;
      logic codec2_handset_tx_a_en;
   } cmx_c2out_t;

   typedef struct packed {
      cmx_sum_t right_adc;
      cmx_sum_t left_adc;
      cmx_sum_t right_dac;
      cmx_sum_t left_dac;
      cmx_atten_t line_atten;
      cmx_mute_t out_mute;
      cmx_mono_t mono_io;
      cmx_c1in_t c1_in;
      cmx_c1out_t c1_out;
      cmx_c2in_t c2_in;
      cmx_c2out_t c2_out;
   } cmx_regs_t;

   // decoded gains in dB, two's complement
   typedef struct packed {
      logic signed [7:0] right_out_db;
      logic signed [7:0] left_out_db;
      logic signed [7:0] mono_in_db;
      logic signed [7:0] codec1_in_db;
      logic signed [7:0] codec1_tx_db;
      logic signed [7:0] codec2_line_rx_db;
      logic signed [7:0] codec2_handset_rx_db;
      logic signed [7:0] codec2_tx_db;
      logic signed [7:0] mic_right_pre_db;
      logic signed [7:0] mic_left_pre_db;
   } cmx_gain_t;

   // serial port pins driven by the codec
   typedef struct packed {
      logic sclk;
      logic fsync;
      logic sout;
   } cmx_sport_t;

endpackage : cmx_pkg

/* File: core/cmx_mute_toggle.sv */
// debounced push-button toggle for the external mute input
`timescale 1ns/10ps
module cmx_mute_toggle #(
   parameter int DEB_CYC = cmx_pkg::MUTE_DEB_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // button pin, low while pressed
   input wire logic mute_btn_n,
   // toggled state, 1 means unmuted
   output logic toggle_state
);
   import cmx_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic s1; // first sync flop
      logic s2; // second sync flop
      logic stable; // debounced button level
      logic [17:0] cnt; // stability counter
      logic state; // toggle output
   } cmx_deb_t;

   cmx_deb_t st_q;
   cmx_deb_t st_d;

   // next state: sync, debounce, toggle on each new press
   always_comb begin
      st_d = st_q;
      st_d.s1 = mute_btn_n;
      st_d.s2 = st_q.s1;
      if (st_q.s2 != st_q.stable) begin
         // level differs, count toward acceptance
         if (st_q.cnt == 18'(DEB_CYC - 1)) begin
            st_d.stable = st_q.s2;
            st_d.cnt = 18'h00000;
            if (!st_q.s2) begin
               st_d.state = ~st_q.state;
            end
         end else begin
            st_d.cnt = st_q.cnt + 18'h00001;
         end
      end else begin
         // bounce seen, restart
         st_d.cnt = 18'h00000;
      end
   end

   // registers, synchronous reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_q <= '{s1: 1'b1, s2: 1'b1, stable: 1'b1, cnt: 18'h00000,
                   state: RST_MUTE_STATE};
      end else begin
         st_q <= st_d;
      end
   end

   assign toggle_state = st_q.state;

endmodule : cmx_mute_toggle

/* File: core/cmx_mixer_regs.sv */
// mixer control register bank reached through the serial frame
`timescale 1ns/10ps

// What this block does
// - right adc summer: six enables, 0 mutes
// - bit 5 loops same-side dac into adc
// - left adc summer uses same layout
// - right dac summer: six active-high enables
// - left dac summer mirrors right layout
// - line attenuation codes: right 3:0, left 7:4
// - attenuation is 3 dB per code step
// - output mute enables bits 0..3, 0 mutes
// - bit 4 reads debounced external mute, 1
// - mono input attenuation 0/-10/-20/-30 dB, reset 01
// - mono output summer gates left/right dac
// - mono loop enable resets to one
// - codec one input gain +0 or +6 dB
// - codec one dac to two transmit pins
// - codec one -6 dB transmit attenuator
// - codec two receive gains -4..+8 dB
// - codec two adc summer input enables
// - codec two three transmit enables, attenuator
// - mic preamp select gives 0 or 20 dB
// - frame carries write flag, index, data
// - frame returns index and register contents
module cmx_mixer_regs #(
   parameter int MUTE_DEB_CYC = cmx_pkg::MUTE_DEB_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial port one, codec side
   input wire logic sin,
   output cmx_pkg::cmx_sport_t sport,
   // external mute button, low while pressed
   input wire logic mute_btn_n,
   // mic preamp selects from the mic gain registers
   input wire logic mic_right_preamp_sel,
   input wire logic mic_left_preamp_sel,
   // controls to the analog mixer
   output cmx_pkg::cmx_regs_t mix_ctrl,
   output cmx_pkg::cmx_gain_t gains
);
   import cmx_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] phase; // clock phase within a bit
      logic [5:0] bit_cnt; // bit position within the frame
      logic sin_s1; // first sync flop
      logic sin_s2; // second sync flop
      logic [15:0] in_sr; // input shift, bits 16..31
      logic [15:0] out_sr; // returned word shifter
      logic [4:0] last_idx; // index of current frame
      cmx_sport_t pins; // driven serial pins
      cmx_regs_t regs; // register contents
      cmx_gain_t gains; // decoded gains
   } cmx_state_t;

   cmx_state_t st_q;
   cmx_state_t st_d;
   logic ext_mute_state; // debounced toggle from the button
   logic [15:0] in_next; // shift register after this sample
   logic [7:0] rd_data; // read data of addressed register
   logic [4:0] fr_idx; // index field of current frame
   logic [7:0] fr_data; // data field of current frame
   logic fr_wr; // write flag of current frame

   // -----------------------------------------------------------------
   // external mute debouncer
   // -----------------------------------------------------------------
   cmx_mute_toggle #(
      .DEB_CYC(MUTE_DEB_CYC)
   ) u_mute (
      .clock(clock),
      .rst_n(rst_n),
      .mute_btn_n(mute_btn_n),
      .toggle_state(ext_mute_state)
   );

   // -----------------------------------------------------------------
   // frame field extraction
   // -----------------------------------------------------------------
   // new sample joins the shift register, msb first
   assign in_next = {st_q.in_sr[14:0], st_q.sin_s2};
   // flag at bit 16, index 19..23, data 24..31
   assign fr_wr = in_next[15];
   assign fr_idx = in_next[12:8];
   assign fr_data = in_next[7:0];

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   // unmapped indexes read as zero
   always_comb begin
      if (st_q.last_idx == IDX_R_ADC) begin
         rd_data = st_q.regs.right_adc;
      end else if (st_q.last_idx == IDX_L_ADC) begin
         rd_data = st_q.regs.left_adc;
      end else if (st_q.last_idx == IDX_R_DAC) begin
         rd_data = st_q.regs.right_dac;
      end else if (st_q.last_idx == IDX_L_DAC) begin
         rd_data = st_q.regs.left_dac;
      end else if (st_q.last_idx == IDX_LINE_ATT) begin
         rd_data = st_q.regs.line_atten;
      end else if (st_q.last_idx == IDX_OUT_MUTE) begin
         rd_data = st_q.regs.out_mute;
      end else if (st_q.last_idx == IDX_MONO_IO) begin
         rd_data = st_q.regs.mono_io;
      end else if (st_q.last_idx == IDX_C1_IN) begin
         rd_data = st_q.regs.c1_in;
      end else if (st_q.last_idx == IDX_C1_OUT) begin
         rd_data = st_q.regs.c1_out;
      end else if (st_q.last_idx == IDX_C2_IN) begin
         rd_data = st_q.regs.c2_in;
      end else if (st_q.last_idx == IDX_C2_OUT) begin
         rd_data = st_q.regs.c2_out;
      end else begin
         rd_data = RST_ZERO;
      end
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // pin synchroniser
      st_d.sin_s1 = sin;
      st_d.sin_s2 = st_q.sin_s1;
      // bit timing
      st_d.phase = st_q.phase + 2'h1;

      st_d.regs.out_mute.external_mute_state = ext_mute_state;

      // clock edges and frame sync
      if (st_q.phase == PH_RISE) begin
         st_d.pins.sclk = 1'b1;
         st_d.pins.fsync = (st_q.bit_cnt == 6'h00);
         if (st_q.bit_cnt == BIT_RET_START) begin
            st_d.out_sr = {3'h0, st_q.last_idx, rd_data};
            st_d.pins.sout = 1'b0;
         end else if (st_q.bit_cnt > BIT_RET_START) begin
            st_d.out_sr = {st_q.out_sr[14:0], 1'b0};
            st_d.pins.sout = st_q.out_sr[RET_MSB - 4'h1];
         end else begin
            st_d.pins.sout = 1'b0;
         end
      end else if (st_q.phase == PH_FALL) begin
         st_d.pins.sclk = 1'b0;
      end

      // sampling and write decode
      if (st_q.phase == PH_SAMP) begin
         st_d.bit_cnt = st_q.bit_cnt + 6'h01;
         if (st_q.bit_cnt >= BIT_WR_FLAG) begin
            if (st_q.bit_cnt <= BIT_DATA_END) begin
               st_d.in_sr = in_next;
            end
         end
         if (st_q.bit_cnt == BIT_DATA_END) begin
            // remember index for the return slot
            st_d.last_idx = fr_idx;
            // write only when the flag is one
            if (fr_wr) begin
               if (fr_idx == IDX_R_ADC) begin
                  st_d.regs.right_adc = cmx_sum_t'(fr_data & MASK_SUM);
               end else if (fr_idx == IDX_L_ADC) begin
                  st_d.regs.left_adc = cmx_sum_t'(fr_data & MASK_SUM);
               end else if (fr_idx == IDX_R_DAC) begin
                  st_d.regs.right_dac = cmx_sum_t'(fr_data & MASK_SUM);
               end else if (fr_idx == IDX_L_DAC) begin
                  st_d.regs.left_dac = cmx_sum_t'(fr_data & MASK_SUM);
               end else if (fr_idx == IDX_LINE_ATT) begin
                  st_d.regs.line_atten = cmx_atten_t'(fr_data & MASK_ATT);
               end else if (fr_idx == IDX_OUT_MUTE) begin
                  st_d.regs.out_mute.right_out1_en = fr_data[0];
                  st_d.regs.out_mute.right_out2_en = fr_data[1];
                  st_d.regs.out_mute.left_out1_en = fr_data[2];
                  st_d.regs.out_mute.left_out2_en = fr_data[3];
               end else if (fr_idx == IDX_MONO_IO) begin
                  st_d.regs.mono_io = cmx_mono_t'(fr_data & MASK_MONO);
               end else if (fr_idx == IDX_C1_IN) begin
                  st_d.regs.c1_in = cmx_c1in_t'(fr_data & MASK_C1_IN);
               end else if (fr_idx == IDX_C1_OUT) begin
                  st_d.regs.c1_out = cmx_c1out_t'(fr_data & MASK_C1_OUT);
               end else if (fr_idx == IDX_C2_IN) begin
                  st_d.regs.c2_in = cmx_c2in_t'(fr_data & MASK_C2_IN);
               end else if (fr_idx == IDX_C2_OUT) begin
                  st_d.regs.c2_out = cmx_c2out_t'(fr_data & MASK_C2_OUT);
               end
            end
         end
      end

      // -----------------------------------------------------------------
      // gain decode from current register contents
      // -----------------------------------------------------------------
      // three dB per attenuation step
      st_d.gains.right_out_db = 8'(-(LOUT_STEP_DB *
         int'(st_q.regs.line_atten.right_out_atten_code)));
      st_d.gains.left_out_db = 8'(-(LOUT_STEP_DB *
         int'(st_q.regs.line_atten.left_out_atten_code)));
      // ten dB per mono input step
      st_d.gains.mono_in_db = 8'(-(MONO_STEP_DB *
         int'(st_q.regs.mono_io.mono_in_atten_sel)));
      st_d.gains.codec1_in_db = st_q.regs.c1_in.codec1_in_gain_sel ?
         8'(C1_IN_GAIN_DB) : 8'h00;
      st_d.gains.codec1_tx_db = st_q.regs.c1_out.codec1_tx_atten ?
         8'(-TX_ATTEN_DB) : 8'h00;
      // receive amplifiers, -4 dB plus 4 per step
      st_d.gains.codec2_line_rx_db = 8'(RX_BASE_DB + RX_STEP_DB *
         int'(st_q.regs.c2_in.codec2_line_rx_gain));
      st_d.gains.codec2_handset_rx_db = 8'(RX_BASE_DB + RX_STEP_DB *
         int'(st_q.regs.c2_in.codec2_handset_rx_gain));
      st_d.gains.codec2_tx_db = st_q.regs.c2_out.codec2_tx_atten ?
         8'(-TX_ATTEN_DB) : 8'h00;
      st_d.gains.mic_right_pre_db = mic_right_preamp_sel ?
         8'(PREAMP_DB) : 8'h00;
      st_d.gains.mic_left_pre_db = mic_left_preamp_sel ?
         8'(PREAMP_DB) : 8'h00;
   end

   // -----------------------------------------------------------------
   // state registers
   // -----------------------------------------------------------------
   // every field takes its reset value
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_q.phase <= 2'h0;
         st_q.bit_cnt <= 6'h00;
         st_q.sin_s1 <= 1'b0;
         st_q.sin_s2 <= 1'b0;
         st_q.in_sr <= 16'h0000;
         st_q.out_sr <= 16'h0000;
         st_q.last_idx <= 5'h00;
         st_q.pins <= '0;
         st_q.regs.right_adc <= cmx_sum_t'(RST_ZERO);
         st_q.regs.left_adc <= cmx_sum_t'(RST_ZERO);
         st_q.regs.right_dac <= cmx_sum_t'(RST_ZERO);
         st_q.regs.left_dac <= cmx_sum_t'(RST_ZERO);
         st_q.regs.line_atten <= cmx_atten_t'(RST_ZERO);
         st_q.regs.out_mute <= cmx_mute_t'(RST_ZERO);
         st_q.regs.out_mute.external_mute_state <= RST_MUTE_STATE;
         // mono loop on, input at -10 dB
         st_q.regs.mono_io <= cmx_mono_t'(RST_MONO);
         st_q.regs.c1_in <= cmx_c1in_t'(RST_ZERO);
         st_q.regs.c1_out <= cmx_c1out_t'(RST_ZERO);
         st_q.regs.c2_in <= cmx_c2in_t'(RST_ZERO);
         st_q.regs.c2_out <= cmx_c2out_t'(RST_ZERO);
         st_q.gains <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // analog controls follow the registers
   assign mix_ctrl = st_q.regs;
   assign gains = st_q.gains;
   assign sport = st_q.pins;

endmodule : cmx_mixer_regs

/* File: dv/cmx_properties.sv */
// port assertions for the mixer control register bank
`timescale 1ns/10ps
module cmx_properties (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial port and mic select
   input cmx_pkg::cmx_sport_t sport,
   input wire logic mic_right_preamp_sel,
   // mixer controls
   input cmx_pkg::cmx_regs_t mix_ctrl,
   input cmx_pkg::cmx_gain_t gains
);
   import cmx_pkg::*;
   logic fs_q; // fsync a clock ago
   logic [7:0] pos_q; // clocks since frame start
   logic [87:0] ctrl_w; // registers less the button state
   assign ctrl_w = mix_ctrl & ~(88'h1 << 44);
   // frame position counter
   always_ff @(posedge clock) begin
      fs_q <= sport.fsync;
      pos_q <= (!rst_n || (sport.fsync && !fs_q)) ? 8'h00 : pos_q + 8'h01;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_bit_clk;
      sport.sclk [*2] ##1 !sport.sclk [*2] ##1 sport.sclk;
   endsequence
   sequence s_sync;
      sport.fsync [*4] ##1 !sport.fsync;
   endsequence
   a_bit_clock: assert property ($rose(sport.sclk) |-> s_bit_clk)
      else $error("bit clock shape wrong");
   a_sync_start: assert property ($rose(sport.fsync) |->
      $rose(sport.sclk) ##0 s_sync) else $error("frame sync wrong");
   a_frame_period: assert property ($rose(sport.fsync) |->
      ##256 $rose(sport.fsync)) else $error("frame not 256 clocks");
   a_sout_quiet: assert property (pos_q > 8'h02 && pos_q < 8'hBC |->
      !sport.sout) else $error("sout busy outside return word");
   a_reg_window: assert property (!$stable(ctrl_w) |->
      pos_q > 8'h78 && pos_q < 8'h88) else $error("register moved off slot");
   a_reserved_zero: assert property (mix_ctrl.right_adc.zero == 2'h0
      && mix_ctrl.out_mute.zero == 3'h0 && mix_ctrl.c2_out.zero == 4'h0)
      else $error("reserved bit set");
   a_atten_db: assert property ($past(rst_n) |-> int'(gains.right_out_db)
      == -LOUT_STEP_DB * int'($past(mix_ctrl.line_atten.right_out_atten_code)))
      else $error("line attenuation decode wrong");
   a_mono_db: assert property ($past(rst_n) |-> int'(gains.mono_in_db)
      == -MONO_STEP_DB * int'($past(mix_ctrl.mono_io.mono_in_atten_sel)))
      else $error("mono attenuation decode wrong");
   a_rx_db: assert property ($past(rst_n) |->
      int'(gains.codec2_line_rx_db) == RX_BASE_DB + RX_STEP_DB *
      int'($past(mix_ctrl.c2_in.codec2_line_rx_gain)))
      else $error("receive gain decode wrong");
   a_preamp_db: assert property ($past(rst_n) |->
      int'(gains.mic_right_pre_db) == ($past(mic_right_preamp_sel) ?
      PREAMP_DB : 0)) else $error("preamp decode wrong");
endmodule : cmx_properties

/* File: dv/cmx_dsp_model.sv */
// behavioural dsp: one register access per serial frame
`timescale 1ns/10ps
module cmx_dsp_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // codec serial port
   input cmx_pkg::cmx_sport_t sport,
   output logic sin,
   // access request, taken at frame start
   input wire logic wr,
   input wire logic [4:0] idx,
   input wire logic [7:0] wdata,
   // returned word and end of frame pulse
   output logic [15:0] ret,
   output logic done
);
   import cmx_pkg::*;
   logic sclk_q; // sclk a clock ago
   logic [5:0] bit_q; // bit now on the line
   logic [5:0] nbit; // bit starting now
   logic [63:0] frm; // frame built at sync, bit 0 at msb
   logic [63:0] frm_q; // frame being sent
   // flag at 16, zero 17..18, index 19..23, data 24..31
   assign frm = {16'hC35A, wr, 2'h0, idx, wdata, 32'h5AC3_0000};
   assign nbit = sport.fsync ? 6'h00 : bit_q + 6'h01;
   // drive half a clock after each sclk rise, so that the codec's
   // two-flop synchroniser holds the new bit before its sample point;
   // take sout after each fall of bits 48..63
   always_ff @(negedge clock) begin
      sclk_q <= sport.sclk;
      done <= 1'b0;
      if (!rst_n) begin
         bit_q <= 6'h00;
         sin <= 1'b0;
      end else if (sport.sclk && !sclk_q) begin
         bit_q <= nbit;
         sin <= sport.fsync ? frm[63] : frm_q[6'h3F - nbit];
         if (sport.fsync) frm_q <= frm;
      end else if (!sport.sclk && sclk_q && bit_q >= 6'h30) begin
         ret <= {ret[14:0], sport.sout};
         done <= (bit_q == 6'h3F);
      end
   end
endmodule : cmx_dsp_model

/* File: dv/tb.sv */
// self-checking bench for the mixer control register bank
`timescale 1ns/10ps
module tb;
   import cmx_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic mute_btn_n = 1'b1;
   logic mic_r = 1'b0;
   logic mic_l = 1'b0;
   logic wr = 1'b0;
   logic [4:0] idx = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic sin;
   logic done;
   logic [15:0] ret;
   cmx_sport_t sport;
   cmx_regs_t mix_ctrl;
   cmx_gain_t gains;
   logic [31:0] seed = 32'h7D04; // xorshift state
   logic [7:0] mdl [32]; // reference registers
   logic [7:0] msk [32]; // writable bits
   int fails = 0;
   int num_checks = 0;
   always #25 clock = ~clock;
   cmx_mixer_regs #(.MUTE_DEB_CYC(8)) i_dut (.clock(clock), .rst_n(rst_n),
      .sin(sin), .sport(sport), .mute_btn_n(mute_btn_n),
      .mic_right_preamp_sel(mic_r), .mic_left_preamp_sel(mic_l),
      .mix_ctrl(mix_ctrl), .gains(gains));
   cmx_dsp_model i_dsp (.clock(clock), .rst_n(rst_n), .sport(sport),
      .sin(sin), .wr(wr), .idx(idx), .wdata(wdata), .ret(ret), .done(done));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic cmx_regs_t regs();
      return {mdl[6], mdl[7], mdl[8], mdl[9], mdl[10], mdl[11], mdl[12],
         mdl[13], mdl[14], mdl[15], mdl[16]};
   endfunction : regs
   task automatic stop_test();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk_val(input logic [87:0] got, input logic [87:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_db(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_db
   // bounded wait for the end of a frame
   task automatic wait_done();
      int n;
      n = 0;
      // step off the pulse of the previous frame first
      @(negedge clock);
      while (done !== 1'b1 && n < 600) begin
         @(negedge clock);
         n++;
      end
      if (done !== 1'b1) begin
         fails++;
         stop_test();
      end
   endtask : wait_done
   // one access frame, then compare return and registers
   task automatic xfer(input logic w, input logic [4:0] i,
      input logic [7:0] d);
      wait_done();
      wr = w;
      idx = i;
      wdata = d;
      wait_done();
      if (w) mdl[i] = (mdl[i] & ~msk[i]) | (d & msk[i]);
      chk_val(ret, {3'h0, i, mdl[i]});
      chk_val(mix_ctrl, regs());
   endtask : xfer
   initial begin
      logic [7:0] d;
      for (int i = 0; i < 32; i++) begin
         mdl[i] = 8'h00;
         msk[i] = 8'h00;
      end
      for (int i = 6; i < 10; i++) msk[i] = MASK_SUM;
      msk[10] = MASK_ATT;
      msk[11] = MASK_MUTE;
      msk[12] = MASK_MONO;
      msk[13] = MASK_C1_IN;
      msk[14] = MASK_C1_OUT;
      msk[15] = MASK_C2_IN;
      msk[16] = MASK_C2_OUT;
      mdl[12] = RST_MONO;
      mdl[11] = {3'h0, RST_MUTE_STATE, 4'h0};
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      chk_val(mix_ctrl, regs());
      for (int i = 6; i < 17; i++) xfer(1'b0, 5'(i), 8'hFF);
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         for (int i = 5; i < 18; i++) begin
            d = (k ? 8'hFF : 8'(xs())) & (i > 5 && i < 17 ? msk[i] : 8'hFF);
            xfer(1'b1, 5'(i), d);
         end
      end
      $display("test write done");
      for (int c = 0; c < 16; c++) begin
         mic_r = c[0];
         mic_l = c[1];
         xfer(1'b1, IDX_LINE_ATT, {4'(15 - c), 4'(c)});
         xfer(1'b1, IDX_MONO_IO, 8'(c));
         xfer(1'b1, IDX_C2_IN, {2'(c), 4'(c), 2'(c >> 2)});
         chk_db(gains.right_out_db, 8'(-LOUT_STEP_DB * c));
         chk_db(gains.left_out_db, 8'(-LOUT_STEP_DB * (15 - c)));
         chk_db(gains.mono_in_db, 8'(-MONO_STEP_DB * (c % 4)));
         chk_db(gains.codec2_line_rx_db, 8'(RX_BASE_DB + 4 * (c % 4)));
         chk_db(gains.codec2_handset_rx_db,
            8'(RX_BASE_DB + 4 * (c >> 2)));
         chk_db(gains.mic_left_pre_db, 8'(c[1] ? PREAMP_DB : 0));
         chk_db(gains.mic_right_pre_db, 8'(c[0] ? PREAMP_DB : 0));
         chk_db(gains.codec1_in_db, 8'(mdl[13][0] ? C1_IN_GAIN_DB : 0));
         chk_db(gains.codec1_tx_db, 8'(mdl[14][2] ? -TX_ATTEN_DB : 0));
         chk_db(gains.codec2_tx_db, 8'(mdl[16][3] ? -TX_ATTEN_DB : 0));
      end
      $display("test gain done");
      mute_btn_n = 1'b0;
      repeat (40) @(negedge clock);
      mute_btn_n = 1'b1;
      repeat (40) @(negedge clock);
      mdl[11] = mdl[11] ^ 8'h10;
      xfer(1'b1, IDX_OUT_MUTE, 8'h1F);
      $display("test mute done");
      stop_test();
   end
endmodule : tb
bind cmx_mixer_regs cmx_properties i_props (.clock(clock), .rst_n(rst_n),
   .sport(sport), .mic_right_preamp_sel(mic_right_preamp_sel),
   .mix_ctrl(mix_ctrl), .gains(gains));
